/* File: bench/fsbl_flash_model.sv */
// Purpose: behavioural flash device with status register and block locks
// Assumes: x16 mode, 8K-word blocks, 16 modelled words per block
// Notes:   operations finish at once; slow_in holds ready low for two status reads
module fsbl_flash_model (
  // flash pins
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rp_n_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  // test control
  input  wire logic        slow_in,
  output logic             bad_cmd_out = 1'b0,
  output logic             bad_order_out = 1'b0,
  output logic             bad_prog_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [512];
  logic [31:0] lock_reg = 32'h0000_0004;
  logic [1:0]  prot_reg = 2'h0;
  logic [7:0]  stat_reg = 8'h80;
  logic [7:0]  pend_reg = 8'h00;
  logic        show_reg = 1'b0;
  logic [15:0] rd_reg = 16'h0000;
  int          busy_left = 0;
  wire  [4:0]  blk = addr_in[17:13];
  wire  [8:0]  idx = {addr_in[17:13], addr_in[3:0]};
  // prot_reg: 0 all treated locked, 1 stored bits apply, 2 nothing locked
  wire         locked = (prot_reg == 2'h0) || (prot_reg == 2'h1 && lock_reg[blk]);
  initial foreach (mem[j]) mem[j] = 16'h5A5A;
  always @(negedge rp_n_in or posedge we_n_in) begin
    if (!rp_n_in) begin
      // stored lock bits survive, but all read as locked
      prot_reg = 2'h0;
      pend_reg = 8'h00;
      show_reg = 1'b0;
    end else if (rp_n_in && pend_reg == 8'h00) begin
      case (dq_in[7:0])
        8'hFF: show_reg = 1'b0;
        8'h70: show_reg = 1'b1;
        8'h50: stat_reg = stat_reg & 8'hC7;
        8'h40, 8'h10, 8'h20, 8'h57, 8'h47, 8'h77, 8'hA7: pend_reg = dq_in[7:0];
        default: bad_cmd_out = 1'b1;
      endcase
    end else if (rp_n_in) begin
      show_reg = 1'b1;
      busy_left = slow_in ? 2 : 0;
      case (pend_reg)
        8'h40, 8'h10: begin
          if (locked) stat_reg = stat_reg | 8'h30;
          else if ((~dq_in & ~mem[idx]) != 16'h0000) bad_prog_out = 1'b1;
          if (!locked) mem[idx] = mem[idx] & dq_in;
        end
        // erase also clears the lock bit
        8'h20: if (locked || dq_in[7:0] != 8'hD0) stat_reg = stat_reg | 8'h20;
          else begin
            for (int i = 0; i < 16; i++) mem[{blk, i[3:0]}] = 16'hFFFF;
            lock_reg[blk] = 1'b0;
          end
        8'h57: if (addr_in[7:0] == 8'hFF) prot_reg = 2'h1;
        8'h47: prot_reg = 2'h2;
        8'h77: begin
          if (prot_reg != 2'h2) bad_order_out = 1'b1;
          lock_reg[blk] = 1'b1;
        end
        // erase uses the stored bits, whatever prot_reg says
        8'hA7: for (int j = 0; j < 512; j++) if (!lock_reg[j[8:4]]) mem[j] = 16'hFFFF;
        default: ;
      endcase
      pend_reg = 8'h00;
    end
  end
  // value latched once per read strobe
  always @(negedge oe_n_in or negedge ce_n_in) begin
    if (!oe_n_in && !ce_n_in) begin
      rd_reg = show_reg ? {8'h00, stat_reg & ((busy_left > 0) ? 8'h7F : 8'hFF)} : mem[idx];
      if (busy_left > 0) busy_left = busy_left - 1;
    end
  end
  // released bus shows the inverse, never a stale value
  assign dq_out = (!ce_n_in && !oe_n_in && rp_n_in) ? rd_reg : ~rd_reg;
endmodule

/* File: bench/fsbl_host_props.sv */
// Purpose: port-level assertions for the flash lock/status host
// Assumes: strobe low for 9 clocks and a 4 clock gap
// Notes:   bound into every fsbl_host instance
module fsbl_host_props (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_N_IN,
  // bus answer
  input  wire logic        HREADYOUT_OUT,
  input  wire logic        HRESP_OUT,
  // flash pins
  input  wire logic        FLASH_CE_N_OUT,
  input  wire logic        FLASH_OE_N_OUT,
  input  wire logic        FLASH_WE_N_OUT,
  input  wire logic        RESET_POWERDOWN_PIN_N_OUT,
  input  wire logic [17:0] FLASH_ADDR_OUT,
  input  wire logic [15:0] FLASH_DQ_OUT,
  input  wire logic        FLASH_DQ_OE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_okay;
    HRESP_OUT == 1'b0 && HREADYOUT_OUT == 1'b1;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready and okay");
  // pin lags release by one edge
  property p_rp;
    $past(RESET_N_IN) |-> RESET_POWERDOWN_PIN_N_OUT;
  endproperty
  a_rp: assert property (p_rp)
    else $error("flash reset pin low outside reset");
  property p_we_len;
    $fell(FLASH_WE_N_OUT) |-> (!FLASH_WE_N_OUT) [*8] ##1 !FLASH_WE_N_OUT ##1 FLASH_WE_N_OUT;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write strobe not nine clocks");
  property p_oe_len;
    $fell(FLASH_OE_N_OUT) |-> (!FLASH_OE_N_OUT) [*8] ##1 !FLASH_OE_N_OUT ##1 FLASH_OE_N_OUT;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("read strobe not nine clocks");
  property p_gap;
    $rose(FLASH_CE_N_OUT) |-> FLASH_CE_N_OUT [*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("chip enable gap too short");
  property p_ce;
    (!FLASH_WE_N_OUT || !FLASH_OE_N_OUT) |-> !FLASH_CE_N_OUT && (FLASH_WE_N_OUT || FLASH_OE_N_OUT);
  endproperty
  a_ce: assert property (p_ce)
    else $error("strobe without chip enable or both strobes low");
  property p_rd_hiz;
    !FLASH_OE_N_OUT |-> !FLASH_DQ_OE_OUT;
  endproperty
  a_rd_hiz: assert property (p_rd_hiz)
    else $error("host drives data during a read");
  property p_wr_hold;
    !FLASH_WE_N_OUT && !$past(FLASH_WE_N_OUT) |->
      FLASH_DQ_OE_OUT && $stable(FLASH_DQ_OUT) && $stable(FLASH_ADDR_OUT);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved during a write strobe");
  c_write: cover property ($fell(FLASH_WE_N_OUT));
  c_read: cover property ($fell(FLASH_OE_N_OUT));
  c_rp: cover property ($rose(RESET_POWERDOWN_PIN_N_OUT));
endmodule

bind fsbl_host fsbl_host_props fsbl_host_props_inst (
  .REF_CLK_IN, .RESET_N_IN, .HREADYOUT_OUT, .HRESP_OUT, .FLASH_CE_N_OUT, .FLASH_OE_N_OUT,
  .FLASH_WE_N_OUT, .RESET_POWERDOWN_PIN_N_OUT, .FLASH_ADDR_OUT, .FLASH_DQ_OUT, .FLASH_DQ_OE_OUT
);

/* File: bench/test_fsbl_host.sv */
// Purpose: self-checking bench for the flash lock/status host
// Assumes: one AHB-Lite master, zero wait states, flash model on the pins
// Notes:   table rows first, then refusal, register, slow-partner and reset cases
module test_fsbl_host;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic clr; logic [3:0] op; logic [17:0] a; logic [15:0] d; logic [1:0] kind;
    logic [15:0] exp;
  } fsbl_row_s;
  // kind: 0 none, 1 status byte, 2 status byte with lock flag at bit 8, 3 read word
  localparam fsbl_row_s ROWS [22] = '{
    '{1'b0, fsbl_pkg::OP_LOCK_TEST, 18'h02000, 16'hFFFF, 2'h2, 16'h01B0},
    '{1'b1, fsbl_pkg::OP_WORD_WRITE, 18'h02001, 16'h1234, 2'h1, 16'h00B0},
    '{1'b1, fsbl_pkg::OP_ERASE_ALL, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_READ_ARRAY, 18'h02005, 16'h0000, 2'h3, 16'hFFFF},
    '{1'b0, fsbl_pkg::OP_READ_ARRAY, 18'h04005, 16'h0000, 2'h3, 16'h5A5A},
    '{1'b0, fsbl_pkg::OP_PROT_SET, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_LOCK_TEST, 18'h02000, 16'hFFFF, 2'h2, 16'h0080},
    '{1'b0, fsbl_pkg::OP_LOCK_TEST, 18'h04000, 16'hFFFF, 2'h2, 16'h01B0},
    '{1'b1, fsbl_pkg::OP_WORD_WRITE, 18'h02001, 16'h1234, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_READ_ARRAY, 18'h02001, 16'h0000, 2'h3, 16'h1234},
    '{1'b0, fsbl_pkg::OP_BLOCK_ERASE, 18'h04000, 16'h0000, 2'h1, 16'h00A0},
    '{1'b1, fsbl_pkg::OP_PROT_RESET, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_WORD_WRITE, 18'h04001, 16'hA5A5, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_READ_ARRAY, 18'h04001, 16'h0000, 2'h3, 16'h0000},
    '{1'b0, fsbl_pkg::OP_LOCK_BLOCK, 18'h06000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_PROT_SET, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_LOCK_TEST, 18'h06000, 16'hFFFF, 2'h2, 16'h01B0},
    '{1'b1, fsbl_pkg::OP_PROT_RESET, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_BLOCK_ERASE, 18'h04000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_PROT_SET, 18'h00000, 16'h0000, 2'h1, 16'h0080},
    '{1'b0, fsbl_pkg::OP_LOCK_TEST, 18'h04000, 16'hFFFF, 2'h2, 16'h0080},
    '{1'b0, fsbl_pkg::OP_READ_STAT, 18'h00000, 16'h0000, 2'h1, 16'h0080}};
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        slow = 1'b0;
  logic [31:0] st;
  logic [31:0] q;
  wire  [31:0] hrdata;
  wire         hready, hresp, ce_n, oe_n, we_n, rp_n, dq_oe, bad_cmd, bad_order, bad_prog;
  wire  [17:0] faddr;
  wire  [15:0] fdq_host, fdq_dev;
  wire  [15:0] fdq = dq_oe ? fdq_host : fdq_dev;
  int          fail_count = 0;
  int          checks_done = 0;
  always #4 ref_clk = ~ref_clk;
  fsbl_host fsbl_host_inst (.REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .FLASH_CE_N_OUT(ce_n), .FLASH_OE_N_OUT(oe_n), .FLASH_WE_N_OUT(we_n),
    .RESET_POWERDOWN_PIN_N_OUT(rp_n), .FLASH_ADDR_OUT(faddr), .FLASH_DQ_OUT(fdq_host),
    .FLASH_DQ_OE_OUT(dq_oe), .FLASH_DQ_IN(fdq));
  fsbl_flash_model fsbl_flash_model_inst (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .rp_n_in(rp_n), .addr_in(faddr), .dq_in(fdq), .dq_out(fdq_dev), .slow_in(slow),
    .bad_cmd_out(bad_cmd), .bad_order_out(bad_order), .bad_prog_out(bad_prog));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up();
    fail_count++;
    $display("mismatch at %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) give_up();
  endtask
  // entered just after a rising edge; holds each phase until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic poll(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      ahb(1'b0, fsbl_pkg::REG_STATUS, 32'h0, s);
      n++;
    end while (s[8] !== 1'b0 && n < 500);
    if (n >= 500) give_up();
  endtask
  task automatic do_op(input logic [3:0] op, input logic [17:0] a, input logic [15:0] d,
                       output logic [31:0] s);
    logic [31:0] r;
    ahb(1'b1, fsbl_pkg::REG_ADDR, {14'h0, a}, r);
    ahb(1'b1, fsbl_pkg::REG_DATA, {16'h0, d}, r);
    ahb(1'b1, fsbl_pkg::REG_CTRL, {28'h0, op}, r);
    poll(s);
  endtask
  initial begin
    repeat (15) @(posedge ref_clk);
    check({31'h0, rp_n}, 32'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].clr) do_op(fsbl_pkg::OP_CLEAR_STAT, 18'h0, 16'h0, st);
      do_op(ROWS[i].op, ROWS[i].a, ROWS[i].d, st);
      if (ROWS[i].kind == 2'h1) check({24'h0, st[7:0]}, {24'h0, ROWS[i].exp[7:0]});
      if (ROWS[i].kind == 2'h2) check({23'h0, st[9], st[7:0]}, {16'h0, ROWS[i].exp});
      if (ROWS[i].kind == 2'h3) begin
        ahb(1'b0, fsbl_pkg::REG_RDATA, 32'h0, q);
        check(q, {16'h0, ROWS[i].exp});
      end
    end
    // a second order while busy must be ignored
    ahb(1'b1, fsbl_pkg::REG_ADDR, 32'h0000_2000, q);
    ahb(1'b1, fsbl_pkg::REG_CTRL, {28'h0, fsbl_pkg::OP_LOCK_TEST}, q);
    ahb(1'b1, fsbl_pkg::REG_CTRL, {28'h0, fsbl_pkg::OP_PROT_RESET}, q);
    poll(st);
    check({22'h0, st[11], st[9], st[7:0]}, 32'h0000_0080);
    ahb(1'b1, fsbl_pkg::REG_STATUS, 32'hFFFF_FFFF, q);
    ahb(1'b0, fsbl_pkg::REG_STATUS, 32'h0, q);
    check(q, st);
    ahb(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    slow <= 1'b1;
    do_op(fsbl_pkg::OP_WORD_WRITE, 18'h02002, 16'h0F0F, st);
    check({24'h0, st[7:0]}, 32'h0000_0080);
    slow <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({30'h0, rp_n, ce_n}, 32'h1);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    do_op(fsbl_pkg::OP_LOCK_TEST, 18'h02000, 16'hFFFF, st);
    check({23'h0, st[9], st[7:0]}, 32'h0000_01B0);
    check({29'h0, bad_cmd, bad_order, bad_prog}, 32'h0);
    stop_test();
  end
endmodule

/* File: src/fsbl_cycle.sv */
// Purpose: performs one asynchronous read or write strobe cycle on the flash pins
// Assumes: pins sampled by two flip-flops; one cycle per start pulse
// Notes:   strobe low time and recovery gap are rounded up to whole clocks

module fsbl_cycle (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // cycle request
  input  wire logic               start_in,
  input  wire fsbl_pkg::fsbl_cyc_s cyc_in,
  output logic                    done_out,
  output logic [15:0]             rdata_out,
  // flash pins
  output logic                    ce_n_out,
  output logic                    oe_n_out,
  output logic                    we_n_out,
  output logic [17:0]             addr_out,
  output logic [15:0]             dq_out,
  output logic                    dq_oe_out,
  input  wire logic [15:0]        dq_in
);

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_STRB = 2'b01,
    CY_GAP  = 2'b10
  } fsbl_cy_e;

  fsbl_cy_e                       st_reg;
  logic [fsbl_pkg::TIMER_W-1:0]   cnt_reg;
  logic [15:0]                    dq_s1_reg;
  logic [15:0]                    dq_s2_reg;
  logic                           wr_reg;

  wire strobe_end = (st_reg == CY_STRB) && (cnt_reg == '0);
  wire gap_end    = (st_reg == CY_GAP) && (cnt_reg == '0);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg    <= CY_IDLE;
      cnt_reg   <= '0;
      wr_reg    <= 1'b0;
      ce_n_out  <= 1'b1;
      oe_n_out  <= 1'b1;
      we_n_out  <= 1'b1;
      addr_out  <= 18'h00000;
      dq_out    <= 16'h0000;
      dq_oe_out <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      case (st_reg)
        CY_IDLE: begin
          if (start_in) begin
            st_reg    <= CY_STRB;
            cnt_reg   <= fsbl_pkg::STROBE_CNT;
            wr_reg    <= cyc_in.wr;
            addr_out  <= cyc_in.addr;
            dq_out    <= cyc_in.data;
            dq_oe_out <= cyc_in.wr;
            ce_n_out  <= 1'b0;
            oe_n_out  <= cyc_in.wr;
            we_n_out  <= !cyc_in.wr;
          end
        end
        CY_STRB: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (strobe_end) begin
            // each read raises ce and oe, so the status value refreshes next time
            // new strobe per read
            st_reg    <= CY_GAP;
            cnt_reg   <= fsbl_pkg::GAP_CNT;
            ce_n_out  <= 1'b1;
            oe_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            if (!wr_reg) begin
              rdata_out <= dq_s2_reg;
            end
          end
        end
        CY_GAP: begin
          cnt_reg   <= cnt_reg - 1'b1;
          dq_oe_out <= 1'b0;
          if (gap_end) begin
            st_reg   <= CY_IDLE;
            done_out <= 1'b1;
          end
        end
        default: st_reg <= CY_IDLE;
      endcase
    end
  end

endmodule

/* File: src/fsbl_host.sv */
// Purpose: host controller that drives a parallel flash for status and block-lock operations
// Assumes: AHB-Lite slave for software, single whole-word transfers, zero wait states (HREADYOUT_OUT always high)
// Notes:   software writes ADDR and DATA, then an op code to CTRL; poll STATUS busy bit

module fsbl_host (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_N_IN,
  // ahb-lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // flash pins
  output logic             FLASH_CE_N_OUT,
  output logic             FLASH_OE_N_OUT,
  output logic             FLASH_WE_N_OUT,
  output logic             RESET_POWERDOWN_PIN_N_OUT,
  output logic [17:0]      FLASH_ADDR_OUT,
  output logic [15:0]      FLASH_DQ_OUT,
  output logic             FLASH_DQ_OE_OUT,
  input  wire logic [15:0] FLASH_DQ_IN
);

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_CYC1  = 3'b001,
    HS_CYC2  = 3'b010,
    HS_POLL  = 3'b011,
    HS_CHECK = 3'b100,
    HS_EXIT  = 3'b101
  } fsbl_hs_e;

  fsbl_hs_e            st_reg;
  logic [3:0]          op_reg;
  logic [17:0]         addr_reg;
  logic [15:0]         data_reg;
  logic [7:0]          status_reg;
  logic [15:0]         rdata_reg;
  logic                locked_reg;
  logic                err_reg;
  logic                prot_off_reg;
  logic                reset_pin_reg;
  logic                start_reg;
  fsbl_pkg::fsbl_cyc_s cyc_reg;
  logic                wr_pend_reg;
  logic [7:0]          wa_reg;

  // ahb decode
  wire        ahb_take   = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire        ahb_wr_now = ahb_take && HWRITE_IN;
  wire        busy       = (st_reg != HS_IDLE);
  wire [31:0] rd_mux     = (HADDR_IN[7:0] == fsbl_pkg::REG_ADDR) ? {14'h0000, addr_reg} :
                           (HADDR_IN[7:0] == fsbl_pkg::REG_DATA) ? {16'h0000, data_reg} :
                           (HADDR_IN[7:0] == fsbl_pkg::REG_STATUS) ?
                             {20'h00000, prot_off_reg, err_reg, locked_reg, busy, status_reg} :
                           (HADDR_IN[7:0] == fsbl_pkg::REG_RDATA) ? {16'h0000, rdata_reg} :
                           (HADDR_IN[7:0] == fsbl_pkg::REG_CTRL) ? {28'h0000000, op_reg} :
                           32'h00000000;

  // cycle engine
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        pin_ce_n;
  logic        pin_oe_n;
  logic        pin_we_n;
  logic [17:0] pin_addr;
  logic [15:0] pin_dq;
  logic        pin_dq_oe;

  fsbl_cycle u_cycle (
    .clk_in    (REF_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .start_in  (start_reg),
    .cyc_in    (cyc_reg),
    .done_out  (cyc_done),
    .rdata_out (cyc_rdata),
    .ce_n_out  (pin_ce_n),
    .oe_n_out  (pin_oe_n),
    .we_n_out  (pin_we_n),
    .addr_out  (pin_addr),
    .dq_out    (pin_dq),
    .dq_oe_out (pin_dq_oe),
    .dq_in     (FLASH_DQ_IN)
  );

  // first command code of each operation, defined codes only
  // defined codes only
  wire [7:0] first_code =
    (op_reg == fsbl_pkg::OP_WORD_WRITE)  ? fsbl_pkg::CMD_WORD_WRITE :
    (op_reg == fsbl_pkg::OP_LOCK_TEST)   ? fsbl_pkg::CMD_WORD_WRITE :
    (op_reg == fsbl_pkg::OP_BLOCK_ERASE) ? fsbl_pkg::CMD_BLOCK_ERASE :
    (op_reg == fsbl_pkg::OP_PROT_SET)    ? fsbl_pkg::CMD_PROT_SET :
    (op_reg == fsbl_pkg::OP_PROT_RESET)  ? fsbl_pkg::CMD_PROT_RESET :
    (op_reg == fsbl_pkg::OP_LOCK_BLOCK)  ? fsbl_pkg::CMD_LOCK_BLOCK :
    (op_reg == fsbl_pkg::OP_ERASE_ALL)   ? fsbl_pkg::CMD_ERASE_ALL :
    (op_reg == fsbl_pkg::OP_CLEAR_STAT)  ? fsbl_pkg::CMD_CLEAR_STATUS :
    (op_reg == fsbl_pkg::OP_READ_STAT)   ? fsbl_pkg::CMD_READ_STATUS :
    fsbl_pkg::CMD_READ_ARRAY;

  wire op_valid   = (HWDATA_IN[3:0] >= fsbl_pkg::OP_WORD_WRITE) &&
                    (HWDATA_IN[3:0] <= fsbl_pkg::OP_READ_STAT);
  wire single_cyc = (op_reg == fsbl_pkg::OP_CLEAR_STAT);
  wire read_only  = (op_reg == fsbl_pkg::OP_READ_STAT) ||
                    (op_reg == fsbl_pkg::OP_READ_ARRAY);

  wire is_prot    = (op_reg == fsbl_pkg::OP_PROT_SET) ||
                    (op_reg == fsbl_pkg::OP_PROT_RESET);
  wire is_wlike   = (op_reg == fsbl_pkg::OP_WORD_WRITE) ||
                    (op_reg == fsbl_pkg::OP_LOCK_TEST);
  wire [15:0] second_data = (op_reg == fsbl_pkg::OP_LOCK_TEST) ? 16'hFFFF :
                            is_wlike ? data_reg : {8'h00, fsbl_pkg::CMD_CONFIRM};
  wire [17:0] second_addr = is_prot ? fsbl_pkg::PROT_ADDR : addr_reg;
  wire [7:0]  st_rd       = cyc_rdata[7:0];
  wire        st_ready    = st_rd[fsbl_pkg::ST_READY];
  wire        st_err      = st_rd[fsbl_pkg::ST_ERASE] || st_rd[fsbl_pkg::ST_PROGRAM] ||
                            st_rd[fsbl_pkg::ST_SUPPLY];
  wire        st_lockpat  = st_ready && st_rd[fsbl_pkg::ST_ERASE] &&
                            st_rd[fsbl_pkg::ST_PROGRAM];
  wire [7:0]  read_cmd    = fsbl_pkg::CMD_READ_ARRAY;

  // ahb register writes land in the data phase
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_pend_reg <= 1'b0;
      wa_reg      <= 8'h00;
    end else begin
      wr_pend_reg <= ahb_wr_now;
      wa_reg      <= HADDR_IN[7:0];
    end
  end

  wire wr_ctrl = wr_pend_reg && (wa_reg == fsbl_pkg::REG_CTRL);
  wire wr_addr = wr_pend_reg && (wa_reg == fsbl_pkg::REG_ADDR);
  wire wr_data = wr_pend_reg && (wa_reg == fsbl_pkg::REG_DATA);

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HRDATA_OUT    <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      HRDATA_OUT    <= (ahb_take && !HWRITE_IN) ? rd_mux : 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      addr_reg <= 18'h00000;
      data_reg <= 16'h0000;
    end else begin
      if (wr_addr && !busy) begin
        addr_reg <= HWDATA_IN[17:0];
      end
      if (wr_data && !busy) begin
        data_reg <= HWDATA_IN[15:0];
      end
    end
  end

  // operation sequencer
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_reg        <= HS_IDLE;
      op_reg        <= 4'h0;
      status_reg    <= 8'h00;
      rdata_reg     <= 16'h0000;
      locked_reg    <= 1'b0;
      err_reg       <= 1'b0;
      prot_off_reg  <= 1'b0;
      reset_pin_reg <= 1'b0;
      start_reg     <= 1'b0;
      cyc_reg       <= '0;
    end else begin
      // flash leaves reset/power-down one clock after our own reset lifts
      reset_pin_reg <= 1'b1;
      start_reg     <= 1'b0;
      case (st_reg)
        HS_IDLE: begin
          if (wr_ctrl && op_valid) begin
            op_reg <= HWDATA_IN[3:0];
            st_reg <= HS_CYC1;
          end
        end

        HS_CYC1: begin
          if (!start_reg) begin
            cyc_reg   <= '{wr: 1'b1, addr: addr_reg, data: {8'h00, first_code}};
            start_reg <= 1'b1;
            st_reg    <= HS_CYC2;
          end
        end

        HS_CYC2: begin
          if (cyc_done) begin
            if (single_cyc) begin
              if (op_reg == fsbl_pkg::OP_CLEAR_STAT) begin
                err_reg <= 1'b0;
              end
              st_reg <= HS_IDLE;
            end else if (read_only) begin
              st_reg <= HS_POLL;
            end else begin
              cyc_reg   <= '{wr: 1'b1, addr: second_addr, data: second_data};
              start_reg <= 1'b1;
              st_reg    <= HS_POLL;
            end
          end
        end

        HS_POLL: begin
          // status is read back directly after the command, no 70H needed
          // reads give status, or array data after OP_READ_ARRAY
          if ((cyc_done || read_only) && !start_reg) begin
            cyc_reg   <= '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
            start_reg <= 1'b1;
            st_reg    <= HS_CHECK;
          end
        end

        HS_CHECK: begin
          if (cyc_done) begin
            status_reg <= st_rd;
            rdata_reg  <= cyc_rdata;
            if (!st_ready && !read_only) begin
              // a fresh strobe is needed to see an updated status
              // re-strobe read
              cyc_reg   <= '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
              start_reg <= 1'b1;
            end else begin
              err_reg <= err_reg || st_err;
              if (op_reg == fsbl_pkg::OP_LOCK_TEST) begin
                locked_reg <= st_lockpat;
              end
              if (op_reg == fsbl_pkg::OP_PROT_RESET) begin
                prot_off_reg <= 1'b1;
              end
              if (op_reg == fsbl_pkg::OP_PROT_SET) begin
                prot_off_reg <= 1'b0;
              end
              cyc_reg   <= '{wr: 1'b1, addr: addr_reg, data: {8'h00, read_cmd}};
              start_reg <= 1'b1;
              st_reg    <= HS_EXIT;
            end
          end
        end

        HS_EXIT: begin
          if (cyc_done) begin
            st_reg <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

  // pins from the cycle engine's own flops, except the reset pin, which comes from reset_pin_reg
  always_comb begin
    FLASH_CE_N_OUT            = pin_ce_n;
    FLASH_OE_N_OUT            = pin_oe_n;
    FLASH_WE_N_OUT            = pin_we_n;
    FLASH_ADDR_OUT            = pin_addr;
    FLASH_DQ_OUT              = pin_dq;
    FLASH_DQ_OE_OUT           = pin_dq_oe;
    RESET_POWERDOWN_PIN_N_OUT = reset_pin_reg;
  end

endmodule

/* File: src/fsbl_pkg.sv */
// Purpose: shared constants and types for the flash lock/status host controller
// Assumes: 16-bit data path to the flash, word addressing
// Notes:   command codes, status bit positions, register offsets and bus timing counts

package fsbl_pkg;

  // command codes issued to the flash
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_WRITE   = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_PROT_SET     = 8'h57;
  localparam logic [7:0] CMD_PROT_RESET   = 8'h47;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL    = 8'hA7;

  // second-cycle address of protect set / reset
  localparam logic [17:0] PROT_ADDR = 18'h000FF;

  // status bit positions
  localparam int ST_READY   = 7;
  localparam int ST_PAUSED  = 6;
  localparam int ST_ERASE   = 5;
  localparam int ST_PROGRAM = 4;
  localparam int ST_SUPPLY  = 3;

  // host operation codes written by software
  localparam logic [3:0] OP_WORD_WRITE  = 4'h1;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h2;
  localparam logic [3:0] OP_PROT_SET    = 4'h3;
  localparam logic [3:0] OP_PROT_RESET  = 4'h4;
  localparam logic [3:0] OP_LOCK_BLOCK  = 4'h5;
  localparam logic [3:0] OP_ERASE_ALL   = 4'h6;
  localparam logic [3:0] OP_CLEAR_STAT  = 4'h7;
  localparam logic [3:0] OP_READ_ARRAY  = 4'h8;
  localparam logic [3:0] OP_LOCK_TEST   = 4'h9;
  localparam logic [3:0] OP_READ_STAT   = 4'hA;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  // strobe timing: 125 MHz, 8 ns clock
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STROBE_MIN_NS  = 60;
  localparam int STROBE_CYCLES  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_MIN_NS     = 30;
  localparam int GAP_CYCLES     = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 4;
  localparam logic [TIMER_W-1:0] STROBE_CNT = TIMER_W'(STROBE_CYCLES);
  localparam logic [TIMER_W-1:0] GAP_CNT    = TIMER_W'(GAP_CYCLES);

  // one bus cycle order to the flash cycle engine
  typedef struct packed {
    logic        wr;
    logic [17:0] addr;
    logic [15:0] data;
  } fsbl_cyc_s;

endpackage
